// ==== hdl/cmx_exec.sv ====
// move/exchange instruction execution unit
`timescale 1ns/1ps

// How it works
// RQ1 - eight byte registers indexed X,A,C,B,E,D,L,H
// RQ2 - pairs AX,BC,DE,HL from high/low halves
// RQ3 - short-direct FE20H..FF1FH, pairs even only
// RQ4 - absolute full space, even for words
// RQ5 - table operand selects even 0040H..007FH
// RQ6 - immediates: word 16, byte 8, bit 3
// RQ7 - flags kept, cleared, set, computed, restored
// RQ8 - clocks counted in CPU clock enable periods
// RQ9 - accumulator A and pair AX
// RQ10 - NMI in-service flag beside interrupt enable
// RQ11 - PROGRAM_STATUS_WORD immediate load: 3 bytes, 6 clocks
// RQ12 - A/X exchange: 1 byte, 4 clocks
// RQ13 - HL+offset move: 2 bytes, 6 clocks
// RQ14 - absolute move: 3 bytes, 8 clocks
// RQ15 - memory exchanges atomic, interrupts held off
module cmx_exec (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  // instruction command
  input  wire logic              cmdValid,
  input  wire cmx_pkg::cmx_op_t  cmdOp,
  input  wire logic [2:0]        cmdReg,
  input  wire logic [1:0]        cmdPair,
  input  wire logic [15:0]       cmdImm,
  input  wire logic [2:0]        cmdBit,
  input  wire logic [4:0]        cmdTbl,
  output logic                   cmdReady,
  output logic                   cmdDone,
  output logic                   cmdFault,
  // memory port
  output logic                   memRd,
  output logic                   memWr,
  output logic [15:0]            memAddr,
  output logic [7:0]             memWdata,
  input  wire logic [7:0]        memRdata,
  // status
  output logic                   intBlock,
  output logic [1:0]             instLen,
  output logic [2:0]             bitSel,
  output logic [15:0]            tblAddr,
  output logic [7:0]             accByte,
  output logic [15:0]            accWord,
  output logic [7:0]             pswOut
);
  import cmx_pkg::*;

  // ==========================================
  // helpers
  function automatic logic saddrOk(input logic [15:0] a, input logic word);
    saddrOk = (a >= SADDR_LO) && (a <= SADDR_HI) && !(word && a[0]); // [RQ3]
  endfunction

  function automatic logic [3:0] clkOf(input cmx_op_t o);
    case (o)
      OP_MOV_A_R, OP_MOV_R_A, OP_MOV_A_SADDR, OP_MOV_SADDR_A, OP_MOV_A_PSW,
      OP_MOV_PSW_A, OP_XCH_A_X, OP_MOVW_AX_RP, OP_MOVW_RP_AX: clkOf = CLK4; // [RQ12]
      OP_MOV_A_ABS, OP_MOV_ABS_A, OP_XCH_A_DE, OP_XCH_A_HL, OP_XCH_A_HLB,
      OP_XCHW_AX_RP: clkOf = CLK8; // [RQ14]
      default: clkOf = CLK6; // [RQ11] [RQ13]
    endcase
  endfunction

  function automatic logic [1:0] lenOf(input cmx_op_t o);
    case (o)
      OP_MOV_A_DE, OP_MOV_DE_A, OP_MOV_A_HL, OP_MOV_HL_A, OP_XCH_A_X,
      OP_XCH_A_DE, OP_XCH_A_HL, OP_MOVW_AX_RP, OP_MOVW_RP_AX, OP_XCHW_AX_RP: lenOf = LEN1;
      OP_MOV_R_IMM, OP_MOV_SADDR_IMM, OP_MOV_A_ABS, OP_MOV_ABS_A, OP_MOV_PSW_IMM,
      OP_MOVW_RP_IMM: lenOf = LEN3; // [RQ11] [RQ14]
      default: lenOf = LEN2; // [RQ13]
    endcase
  endfunction

  // ==========================================
  // state
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WRITE} cmx_state_t;
  cmx_state_t  state_r;
  logic [7:0]  regs_r [8];
  logic [7:0]  psw_r;
  logic [3:0]  cnt_r;
  cmx_op_t     op_r;
  logic [2:0]  reg_r;
  logic [1:0]  pair_r;
  logic [15:0] imm_r;
  logic [15:0] addr_r;
  logic        isMem_r;
  logic        isWr_r;
  logic        isXchMem_r;
  logic        done_r;
  logic        fault_r;
  logic [1:0]  len_r;
  logic [2:0]  bit_r;
  logic [15:0] tbl_r;

  logic [15:0] hlVal;
  logic [15:0] deVal;
  logic [15:0] effAddr;
  logic        addrOk;
  logic        memKind;
  logic        wrKind;
  logic        start;

  assign hlVal = {regs_r[REG_H], regs_r[REG_L]}; // [RQ2]
  assign deVal = {regs_r[REG_D], regs_r[REG_E]};
  assign start = clkEn && cmdValid && (state_r == ST_IDLE);

  // effective address and legality
  always_comb begin
    effAddr = cmdImm;
    addrOk  = 1'b1;
    memKind = 1'b0;
    wrKind  = 1'b0;
    case (cmdOp)
      OP_MOV_SADDR_IMM, OP_MOV_SADDR_A: begin
        addrOk  = saddrOk(cmdImm, 1'b0); // [RQ3]
        memKind = 1'b1;
        wrKind  = 1'b1;
      end
      OP_MOV_A_SADDR, OP_XCH_A_SADDR: begin
        addrOk  = saddrOk(cmdImm, 1'b0);
        memKind = 1'b1;
      end
      OP_MOV_A_ABS: memKind = 1'b1; // [RQ4]
      OP_MOV_ABS_A: begin
        memKind = 1'b1;
        wrKind  = 1'b1;
      end
      OP_MOV_A_DE, OP_XCH_A_DE: begin
        effAddr = deVal;
        memKind = 1'b1;
      end
      OP_MOV_DE_A: begin
        effAddr = deVal;
        memKind = 1'b1;
        wrKind  = 1'b1;
      end
      OP_MOV_A_HL, OP_XCH_A_HL: begin
        effAddr = hlVal;
        memKind = 1'b1;
      end
      OP_MOV_HL_A: begin
        effAddr = hlVal;
        memKind = 1'b1;
        wrKind  = 1'b1;
      end
      OP_MOV_A_HLB, OP_XCH_A_HLB: begin
        effAddr = hlVal + {8'h00, cmdImm[7:0]}; // [RQ13]
        memKind = 1'b1;
      end
      OP_MOV_HLB_A: begin
        effAddr = hlVal + {8'h00, cmdImm[7:0]};
        memKind = 1'b1;
        wrKind  = 1'b1;
      end
      OP_XCH_A_R: addrOk = (cmdReg != REG_A) && (cmdReg != REG_X);
      OP_MOV_A_R, OP_MOV_R_A: addrOk = (cmdReg != REG_A);
      OP_MOVW_AX_RP, OP_MOVW_RP_AX, OP_XCHW_AX_RP: addrOk = (cmdPair != RP_AX);
      default: addrOk = 1'b1;
    endcase
  end

  // ==========================================
  // sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 4'h0;
      op_r       <= OP_MOV_A_R;
      reg_r      <= 3'h0;
      pair_r     <= 2'h0;
      imm_r      <= 16'h0000;
      addr_r     <= 16'h0000;
      isMem_r    <= 1'b0;
      isWr_r     <= 1'b0;
      isXchMem_r <= 1'b0;
      done_r     <= 1'b0;
      fault_r    <= 1'b0;
      len_r      <= 2'h0;
      bit_r      <= 3'h0;
      tbl_r      <= 16'h0000;
    end else if (clkEn) begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmdValid) begin
            op_r       <= cmdOp;
            reg_r      <= cmdReg;
            pair_r     <= cmdPair;
            imm_r      <= cmdImm; // [RQ6]
            addr_r     <= effAddr;
            isMem_r    <= memKind;
            isWr_r     <= wrKind;
            isXchMem_r <= (cmdOp == OP_XCH_A_SADDR) || (cmdOp == OP_XCH_A_DE) ||
                          (cmdOp == OP_XCH_A_HL) || (cmdOp == OP_XCH_A_HLB);
            len_r      <= lenOf(cmdOp);
            bit_r      <= cmdBit; // [RQ6]
            if (cmdOp == OP_TBL_ADDR) begin
              tbl_r <= TBL_BASE + {10'h000, cmdTbl, 1'b0}; // [RQ5]
            end
            fault_r    <= !addrOk;
            cnt_r      <= clkOf(cmdOp) - 4'h1; // [RQ8]
            state_r    <= addrOk ? ST_RUN : ST_IDLE;
            done_r     <= !addrOk;
          end
        end
        ST_RUN: begin
          cnt_r <= cnt_r - 4'h1; // [RQ8]
          if (isXchMem_r && cnt_r == 4'h2) begin
            state_r <= ST_WRITE;
          end else if (cnt_r == 4'h1) begin
            state_r <= ST_IDLE;
            done_r  <= 1'b1;
          end
        end
        ST_WRITE: begin
          state_r <= ST_IDLE;
          done_r  <= 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // register file and flags
  // read data stands one enabled cycle after the strobe, i.e. on the last step
  logic readPhase;
  assign readPhase = isMem_r && !isWr_r &&
                     (((state_r == ST_RUN) && (cnt_r == 4'h1)) || (state_r == ST_WRITE));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        regs_r[i] <= 8'h00;
      end
      psw_r <= PSW_RESET;
    end else if (clkEn && readPhase) begin
      regs_r[REG_A] <= memRdata; // [RQ15]
    end else if (clkEn && state_r == ST_RUN && cnt_r == 4'h2) begin
      case (op_r)
        OP_MOV_R_IMM: regs_r[reg_r] <= imm_r[7:0]; // [RQ1]
        OP_MOV_A_R: regs_r[REG_A] <= regs_r[reg_r];
        OP_MOV_R_A: regs_r[reg_r] <= regs_r[REG_A];
        OP_MOV_A_PSW: regs_r[REG_A] <= psw_r;
        OP_MOV_PSW_IMM: psw_r <= (psw_r & ~PSW_LOAD_MASK) | (imm_r[7:0] & PSW_LOAD_MASK); // [RQ11] [RQ7]
        OP_MOV_PSW_A: psw_r <= (psw_r & ~PSW_LOAD_MASK) | (regs_r[REG_A] & PSW_LOAD_MASK); // [RQ7]
        OP_XCH_A_X: begin
          regs_r[REG_A] <= regs_r[REG_X]; // [RQ12]
          regs_r[REG_X] <= regs_r[REG_A];
        end
        OP_XCH_A_R: begin
          regs_r[REG_A] <= regs_r[reg_r];
          regs_r[reg_r] <= regs_r[REG_A];
        end
        OP_MOVW_RP_IMM: begin
          regs_r[{pair_r, 1'b1}] <= imm_r[15:8]; // [RQ2]
          regs_r[{pair_r, 1'b0}] <= imm_r[7:0];
        end
        OP_MOVW_AX_RP: begin
          regs_r[REG_A] <= regs_r[{pair_r, 1'b1}]; // [RQ9]
          regs_r[REG_X] <= regs_r[{pair_r, 1'b0}];
        end
        OP_MOVW_RP_AX: begin
          regs_r[{pair_r, 1'b1}] <= regs_r[REG_A];
          regs_r[{pair_r, 1'b0}] <= regs_r[REG_X];
        end
        OP_XCHW_AX_RP: begin
          regs_r[REG_A] <= regs_r[{pair_r, 1'b1}];
          regs_r[REG_X] <= regs_r[{pair_r, 1'b0}];
          regs_r[{pair_r, 1'b1}] <= regs_r[REG_A];
          regs_r[{pair_r, 1'b0}] <= regs_r[REG_X];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // memory strobes and data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memRd    <= 1'b0;
      memWr    <= 1'b0;
      memAddr  <= 16'h0000;
      memWdata <= 8'h00;
    end else if (clkEn) begin
      memRd <= (state_r == ST_RUN) && isMem_r && !isWr_r && (cnt_r == 4'h3);
      memWr <= ((state_r == ST_RUN) && isMem_r && isWr_r && (cnt_r == 4'h3)) ||
               ((state_r == ST_RUN) && isXchMem_r && (cnt_r == 4'h2)); // [RQ15]
      memAddr <= addr_r;
      if (op_r == OP_MOV_SADDR_IMM) begin
        memWdata <= imm_r[7:0];
      end else begin
        memWdata <= regs_r[REG_A];
      end
    end
  end

  // ==========================================
  // outputs
  assign cmdReady = (state_r == ST_IDLE);
  assign cmdDone  = done_r;
  assign cmdFault = fault_r;
  assign intBlock = (state_r != ST_IDLE) && isXchMem_r; // [RQ15]
  assign instLen  = len_r;
  assign bitSel   = bit_r;
  assign tblAddr  = tbl_r;
  assign accByte  = regs_r[REG_A]; // [RQ9]
  assign accWord  = {regs_r[REG_A], regs_r[REG_X]};
  assign pswOut   = psw_r; // [RQ10]

endmodule // cmx_exec

// ==== hdl/cmx_pkg.sv ====
// package: constants and types for the move/exchange execution unit
package cmx_pkg;

  // ==========================================
  // register indices
  localparam logic [2:0] REG_X = 3'h0;
  localparam logic [2:0] REG_A = 3'h1;
  localparam logic [2:0] REG_C = 3'h2;
  localparam logic [2:0] REG_B = 3'h3;
  localparam logic [2:0] REG_E = 3'h4;
  localparam logic [2:0] REG_D = 3'h5;
  localparam logic [2:0] REG_L = 3'h6;
  localparam logic [2:0] REG_H = 3'h7;
  localparam logic [1:0] RP_AX = 2'h0;
  localparam logic [1:0] RP_BC = 2'h1;
  localparam logic [1:0] RP_DE = 2'h2;
  localparam logic [1:0] RP_HL = 2'h3;

  // ==========================================
  // address ranges
  localparam logic [15:0] SADDR_LO = 16'hFE20;
  localparam logic [15:0] SADDR_HI = 16'hFF1F;
  localparam logic [15:0] TBL_BASE = 16'h0040;

  // ==========================================
  // program status word bit positions and reset value
  localparam int PSW_CY   = 0;
  localparam int PSW_NMI_IN_SERVICE_FLAG = 1;
  localparam int PSW_AC   = 4;
  localparam int PSW_Z    = 6;
  localparam int PSW_IE   = 7;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam logic [7:0] PSW_LOAD_MASK = 8'h51;

  // ==========================================
  // byte counts and clock counts
  localparam logic [3:0] CLK4 = 4'h4;
  localparam logic [3:0] CLK6 = 4'h6;
  localparam logic [3:0] CLK8 = 4'h8;
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;

  // ==========================================
  // operation codes on the command port
  typedef enum logic [4:0] {
    OP_MOV_R_IMM, OP_MOV_SADDR_IMM, OP_MOV_A_R, OP_MOV_R_A,
    OP_MOV_A_SADDR, OP_MOV_SADDR_A, OP_MOV_A_ABS, OP_MOV_ABS_A,
    OP_MOV_PSW_IMM, OP_MOV_A_PSW, OP_MOV_PSW_A,
    OP_MOV_A_DE, OP_MOV_DE_A, OP_MOV_A_HL, OP_MOV_HL_A,
    OP_MOV_A_HLB, OP_MOV_HLB_A,
    OP_XCH_A_X, OP_XCH_A_R, OP_XCH_A_SADDR,
    OP_XCH_A_DE, OP_XCH_A_HL, OP_XCH_A_HLB,
    OP_MOVW_RP_IMM, OP_MOVW_AX_RP, OP_MOVW_RP_AX, OP_XCHW_AX_RP,
    OP_TBL_ADDR
  } cmx_op_t;

  typedef enum logic [1:0] {FLG_KEEP, FLG_CLR, FLG_SET, FLG_LOAD} cmx_flag_t;

endpackage

// ==== verif/cmx_exec_assertions.sv ====
// assertions on the ports of the move/exchange unit
`timescale 1ns/1ps
module cmx_exec_assertions
  import cmx_pkg::*;
(
  // clock and command
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic             clkEn,
  input wire logic             cmdValid,
  input wire cmx_pkg::cmx_op_t cmdOp,
  input wire logic [2:0]       cmdReg,
  input wire logic [15:0]      cmdImm,
  input wire logic             cmdReady,
  // results
  input wire logic             cmdDone,
  input wire logic             cmdFault,
  input wire logic             intBlock,
  input wire logic [1:0]       instLen,
  input wire logic [15:0]      accWord,
  input wire logic [7:0]       pswOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] immByte;
  assign immByte = cmdImm[7:0];
  // ==========================================
  // command acceptance
  sequence take;
    clkEn && cmdValid && cmdReady;
  endsequence
  a_xch_x_time: assert property (take ##0 cmdOp == OP_XCH_A_X ##1 clkEn [*3] |=> cmdDone && instLen == LEN1)
    else $error("exchange with X off time");
  a_psw_load_val: assert property (take ##0 cmdOp == OP_MOV_PSW_IMM ##1 clkEn [*5] |=> cmdDone && instLen == LEN3
    && pswOut == (($past(pswOut, 6) & ~PSW_LOAD_MASK) | ($past(immByte, 6) & PSW_LOAD_MASK)))
    else $error("status word load wrong");
  a_abs_move_time: assert property (take ##0 (cmdOp == OP_MOV_A_ABS || cmdOp == OP_MOV_ABS_A)
    ##1 clkEn [*7] |=> cmdDone && instLen == LEN3)
    else $error("absolute move off time");
  a_offset_move_time: assert property (take ##0 (cmdOp == OP_MOV_A_HLB || cmdOp == OP_MOV_HLB_A)
    ##1 clkEn [*5] |=> cmdDone && instLen == LEN2)
    else $error("offset move off time");
  a_xch_mem_block: assert property (take ##0 (cmdOp inside {OP_XCH_A_DE, OP_XCH_A_HL, OP_XCH_A_HLB})
    |=> intBlock [*6])
    else $error("memory exchange not guarded");
  a_saddr_refuse: assert property (take ##0 (cmdOp == OP_MOV_A_SADDR &&
    (cmdImm < SADDR_LO || cmdImm > SADDR_HI)) |=> cmdDone && cmdFault && $stable(accWord))
    else $error("short address outside range taken");
  a_self_move_refuse: assert property (take ##0 cmdOp == OP_MOV_A_R && cmdReg == REG_A |=> cmdDone && cmdFault)
    else $error("move of A to A taken");
  a_freeze_state: assert property (!clkEn |=> $stable(accWord) && $stable(pswOut) && $stable(cmdDone))
    else $error("state moved without clock enable");
endmodule // cmx_exec_assertions

bind cmx_exec cmx_exec_assertions cmx_exec_assertions_inst (
  .ref_clk, .rst, .clkEn, .cmdValid, .cmdOp, .cmdReg, .cmdImm, .cmdReady,
  .cmdDone, .cmdFault, .intBlock, .instLen, .accWord, .pswOut
);

// ==== verif/test_cmx_exec.sv ====
// self-checking bench for the move/exchange unit
`timescale 1ns/1ps
module test_cmx_exec;
  import cmx_pkg::*;
  // ==========================================
  // signals
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        slow = 1'b0;
  logic        cmdValid = 1'b0;
  cmx_op_t     cmdOp = OP_MOV_A_R;
  logic [2:0]  cmdReg = 3'h0;
  logic [2:0]  cmdBit = 3'h0;
  logic [1:0]  cmdPair = 2'h0;
  logic [4:0]  cmdTbl = 5'h00;
  logic [15:0] cmdImm = 16'h0000;
  logic [7:0]  memRdata = 8'h00;
  logic        cmdReady, cmdDone, cmdFault, memRd, memWr, intBlock;
  logic [1:0]  instLen;
  logic [2:0]  bitSel;
  logic [7:0]  memWdata, accByte, pswOut, v, ps;
  logic [15:0] memAddr, tblAddr, accWord, a16;
  logic [15:0] lf = 16'h2A32;
  logic [15:0] ce = 16'h2A32;
  logic [7:0]  mem [65536];
  logic [7:0]  r [8];
  int          n_mismatch = 0;
  int          n_tests = 0;
  cmx_op_t     rd [6] = '{OP_MOV_A_DE, OP_MOV_A_HL, OP_MOV_A_HLB, OP_XCH_A_DE, OP_XCH_A_HL, OP_XCH_A_HLB};
  logic [15:0] sa [4] = '{16'hFE20, 16'hFF1F, 16'hFE1F, 16'hFF20};
  logic [15:0] ab [3] = '{16'h0000, 16'hFFFF, 16'h0000};

  cmx_exec cmx_exec_inst (
    .ref_clk, .rst, .clkEn, .cmdValid, .cmdOp, .cmdReg, .cmdPair, .cmdImm, .cmdBit, .cmdTbl,
    .cmdReady, .cmdDone, .cmdFault, .memRd, .memWr, .memAddr, .memWdata, .memRdata,
    .intBlock, .instLen, .bitSel, .tblAddr, .accByte, .accWord, .pswOut
  );

  always #12.5 ref_clk = ~ref_clk;

  // random clock enable while slow, memory with one-cycle read latency
  always @(posedge ref_clk) begin
    ce <= nx(ce);
    clkEn <= !slow | ce[0];
    if (clkEn) begin
      if (memWr) mem[memAddr] <= memWdata;
      memRdata <= memRd ? mem[memAddr] : ~memRdata;
    end
  end

  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [15:0] ea(input cmx_op_t op, input logic [7:0] off);
    case (op)
      OP_MOV_A_DE, OP_XCH_A_DE: return {r[5], r[4]};
      OP_MOV_A_HLB, OP_XCH_A_HLB: return {r[7], r[6]} + {8'h00, off};
      default: return {r[7], r[6]};
    endcase
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // issue one command, count enabled clocks until done
  task automatic run(input cmx_op_t op, input logic [15:0] imm, input logic [2:0] rg, input logic [1:0] rp,
                     input int clk, input logic flt);
    int n;
    cmdOp <= op;
    cmdImm <= imm;
    cmdReg <= rg;
    cmdPair <= rp;
    cmdValid <= 1'b1;
    n = 0;
    do @(posedge ref_clk); while (!(clkEn && cmdReady) && ++n < 99);
    cmdValid <= 1'b0;
    n = 1;
    @(posedge ref_clk);
    while (cmdDone !== 1'b1 && n < 99) begin
      n += clkEn;
      @(posedge ref_clk);
    end
    if (clk > 0) chk("clocks", 16'(clk), 16'(n));
    chk("fault", {15'h0000, flt}, {15'h0000, cmdFault});
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // scenarios
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("psw", PSW_RESET, pswOut);
    ps = PSW_RESET;
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      a16 = i == 0 ? 16'h00FF : lf;
      run(OP_MOV_PSW_IMM, a16, 3'h0, 2'h0, 6, 1'b0);
      ps = (ps & ~PSW_LOAD_MASK) | (a16[7:0] & PSW_LOAD_MASK);
      chk("psw", ps, pswOut);
      run(OP_MOV_A_PSW, a16, 3'h0, 2'h0, 4, 1'b0);
      chk("a", ps, accByte);
    end
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      r[i] = lf[7:0];
      run(OP_MOV_R_IMM, lf, 3'(i), 2'h0, 6, 1'b0);
    end
    chk("ax", {r[1], r[0]}, accWord);
    for (int i = 0; i < 8; i++) begin
      run(OP_MOV_A_R, 16'h0000, 3'(i), 2'h0, i == 1 ? 1 : 4, i == 1);
      r[1] = r[i];
      chk("a", r[i], accByte);
    end
    run(OP_XCH_A_R, 16'h0000, REG_C, 2'h0, 6, 1'b0);
    v = r[2];
    r[2] = r[1];
    r[1] = v;
    chk("a", v, accByte);
    run(OP_XCH_A_R, 16'h0000, REG_X, 2'h0, 1, 1'b1);
    run(OP_MOVW_AX_RP, 16'h0000, 3'h0, RP_AX, 1, 1'b1);
    for (int p = 1; p < 4; p++) begin
      lf = nx(lf);
      run(OP_MOVW_RP_IMM, lf, 3'h0, 2'(p), 6, 1'b0);
      run(OP_MOV_A_R, 16'h0000, 3'(2 * p + 1), 2'h0, 4, 1'b0);
      chk("a", lf[15:8], accByte);
      run(OP_MOVW_AX_RP, 16'h0000, 3'h0, 2'(p), 4, 1'b0);
      chk("ax", lf, accWord);
      {r[2 * p + 1], r[2 * p], r[1], r[0]} = {lf, lf};
    end
    foreach (rd[k]) begin
      lf = nx(lf);
      a16 = ea(rd[k], lf[7:0]);
      v = r[1];
      mem[a16] = lf[15:8];
      run(rd[k], lf, 3'h0, 2'h0, k > 2 ? 8 : 6, 1'b0);
      r[1] = lf[15:8];
      chk("a", r[1], accByte);
      if (k > 2) chk("mem", v, mem[a16]);
    end
    foreach (ab[k]) begin
      lf = nx(lf);
      a16 = k == 2 ? lf : ab[k];
      mem[a16] = lf[15:8];
      run(OP_MOV_A_ABS, a16, 3'h0, 2'h0, 8, 1'b0);
      r[1] = lf[15:8];
      chk("a", r[1], accByte);
      run(OP_MOV_ABS_A, a16 ^ 16'h0001, 3'h0, 2'h0, 8, 1'b0);
      chk("mem", r[1], mem[a16 ^ 16'h0001]);
    end
    foreach (sa[k]) begin
      lf = nx(lf);
      mem[sa[k]] = lf[7:0];
      run(OP_MOV_A_SADDR, sa[k], 3'h0, 2'h0, k > 1 ? 1 : 4, k > 1);
      if (k < 2) r[1] = lf[7:0];
      chk("a", r[1], accByte);
    end
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      v = i == 0 ? 8'h00 : i == 1 ? 8'h1F : lf[7:0];
      cmdTbl <= v[4:0];
      cmdBit <= lf[10:8];
      run(OP_TBL_ADDR, 16'h0000, 3'h0, 2'h0, 0, 1'b0);
      chk("table", 16'h0040 + {10'h000, v[4:0], 1'b0}, tblAddr);
      chk("bit", {13'h0000, lf[10:8]}, {13'h0000, bitSel});
    end
    for (int i = 0; i < 5; i++) begin
      slow <= i > 0;
      run(OP_XCH_A_X, 16'h0000, 3'h0, 2'h0, 4, 1'b0);
      {r[1], r[0]} = {r[0], r[1]};
      chk("ax", {r[1], r[0]}, accWord);
    end
    end_of_test();
  end

  // watchdog: the whole sequence needs well under 3000 clocks
  initial begin
    #(25 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule // test_cmx_exec
